// >>> logic/irq_combiner_defs.svh
`ifndef IRQ_COMBINER_DEFS_SVH
`define IRQ_COMBINER_DEFS_SVH

// register byte offsets
`define OFS_INT_CONTROL 12'h00C
`define OFS_RXTH_MASK 12'h010
`define OFS_RX_MASK 12'h014
`define OFS_TX_MASK 12'h018
`define OFS_MISC_MASK 12'h01C
`define OFS_RXTH_STATE 12'h020
`define OFS_RX_STATE 12'h024
`define OFS_TX_STATE 12'h028
`define OFS_MISC_STATE 12'h02C
`define OFS_RX_LIMIT 12'h030
`define OFS_TX_LIMIT 12'h034
`define OFS_EVT_STATUS 12'h040
`define OFS_EVT_MASK 12'h044

// control fields
`define BIT_TX_PACE 21
`define BIT_RX_PACE 20
`define PRESCALE_MSB 11
`define MISC_STAT_BIT 5
`define MISC_HOST_BIT 4
`define MISC_LINK_BIT 2
`define MISC_USER_BIT 0
`define MISC_VALID_MASK 6'h35

// reset values
`define RST_INT_CONTROL 32'h0000_00A0
`define RST_LIMIT 6'h3F

// timing
`define PRESCALE_US 4
`define WINDOW_US 1000
`define WINDOW_TICKS (`WINDOW_US / `PRESCALE_US)
`define MCLK_MHZ 40

`endif

// >>> logic/irq_combiner_pkg.sv
package irq_combiner_pkg;

  typedef enum logic [1:0] {
    PACE_OPEN = 2'b00,
    PACE_FULL = 2'b01
  } pace_state_e;

  typedef logic [5:0] rate_t;

endpackage

// >>> logic/pace_link_if.sv
`timescale 1ns/1ps
interface pace_link_if;
  logic tick_ms;
  logic enable;
  logic [5:0] limit;
  logic request;
  logic pulse;
  modport ctl (output tick_ms, output enable, output limit, output request, input pulse);
  modport pacer (input tick_ms, input enable, input limit, input request, output pulse);
endinterface

// >>> logic/pulse_pacer.sv
`timescale 1ns/1ps
`include "irq_combiner_defs.svh"
module pulse_pacer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control and pulse
  pace_link_if.pacer lnk
);
  irq_combiner_pkg::pace_state_e state;
  irq_combiner_pkg::pace_state_e next_state;
  irq_combiner_pkg::rate_t count;
  irq_combiner_pkg::rate_t next_count;
  logic prev_pulse;
  logic pulse_out;
  logic pulse_rise;

  // tally output rises, not request rises: a pulse reopened at a window start
  // is charged to the new window
  assign pulse_rise = pulse_out & ~prev_pulse;

  always_comb begin
    next_state = state;
    next_count = count;
    if (!lnk.enable || lnk.tick_ms) begin
      // window restart re-opens the gate; pacing off keeps the tally idle
      next_state = irq_combiner_pkg::PACE_OPEN;
      next_count = '0;
    end else begin
      case (state)
        irq_combiner_pkg::PACE_OPEN: begin
          if (pulse_rise) begin
            next_count = count + 6'h01;
          end
          // limit reached: hold off until next window
          if ((count + (pulse_rise ? 6'h01 : 6'h00)) >= lnk.limit) begin
            next_state = irq_combiner_pkg::PACE_FULL;
          end
        end
        irq_combiner_pkg::PACE_FULL: next_state = irq_combiner_pkg::PACE_FULL;
        default: next_state = irq_combiner_pkg::PACE_OPEN;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= irq_combiner_pkg::PACE_OPEN;
      count <= '0;
      prev_pulse <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      prev_pulse <= pulse_out;
    end
  end

  // unpaced passes straight through
  assign pulse_out = lnk.request &
    (~lnk.enable | (state == irq_combiner_pkg::PACE_OPEN && count < lnk.limit));
  assign lnk.pulse = pulse_out;

  AST_PACE_BLOCK: assert property (@(posedge mclk) disable iff (!rst_b)
    (lnk.enable && state == irq_combiner_pkg::PACE_FULL && !lnk.tick_ms) |-> !lnk.pulse)
    else $error("paced pulse leaked past limit");
  AST_UNPACED: assert property (@(posedge mclk) disable iff (!rst_b)
    !lnk.enable |-> (lnk.pulse == lnk.request))
    else $error("unpaced pulse differs from request");
endmodule

// >>> logic/irq_combiner.sv
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "irq_combiner_defs.svh"
module irq_combiner #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // raw interrupt sources
  input wire logic [CHANNELS-1:0] rx_thresh_src,
  input wire logic [CHANNELS-1:0] rx_src,
  input wire logic [CHANNELS-1:0] tx_src,
  input wire logic statistics_src,
  input wire logic host_error_src,
  input wire logic link_change_src,
  input wire logic phy_access_src,
  // interrupt lines
  output logic receive_threshold_irq_line,
  output logic receive_irq_line,
  output logic transmit_irq_line,
  output logic misc_irq_line,
  output logic irq
);
  logic [31:0] int_control;
  logic [31:0] next_int_control;
  logic [CHANNELS-1:0] receive_threshold_mask_bits;
  logic [CHANNELS-1:0] next_rxth_mask;
  logic [CHANNELS-1:0] rx_mask;
  logic [CHANNELS-1:0] next_rx_mask;
  logic [CHANNELS-1:0] tx_mask;
  logic [CHANNELS-1:0] next_tx_mask;
  logic [5:0] misc_mask;
  logic [5:0] next_misc_mask;
  logic [5:0] receive_pulse_rate_limit;
  logic [5:0] next_rx_limit;
  logic [5:0] transmit_pulse_rate_limit;
  logic [5:0] next_tx_limit;
  logic [3:0] evt_status;
  logic [3:0] next_evt_status;
  logic [3:0] evt_mask;
  logic [3:0] next_evt_mask;
  logic [11:0] pre_cnt;
  logic [11:0] next_pre_cnt;
  logic [7:0] win_cnt;
  logic [7:0] next_win_cnt;
  logic tick_ms;
  logic [CHANNELS-1:0] rxth_sync1, rxth_sync2, rx_sync1, rx_sync2, tx_sync1, tx_sync2;
  logic [3:0] misc_sync1, misc_sync2;
  logic [3:0] misc_prev;
  logic [CHANNELS-1:0] receive_threshold_masked_state;
  logic [CHANNELS-1:0] rx_masked;
  logic [CHANNELS-1:0] tx_masked;
  logic [5:0] misc_raw;
  logic [5:0] misc_active;
  logic [3:0] evt_rise;
  logic wr_en;
  logic [31:0] rd_mux;
  logic [31:0] next_prdata;
  logic hit;
  logic transmit_pacing_enable;
  logic receive_pacing_enable;
  logic statistics_irq_enable, host_error_irq_enable;
  logic link_change_irq_enable, phy_access_irq_enable;
  logic statistics_irq_flag, host_error_irq_flag, link_change_irq_flag, phy_access_irq_flag;

  pace_link_if rx_lnk ();
  pace_link_if tx_lnk ();

  function automatic logic [31:0] widen(input logic [CHANNELS-1:0] v);
    widen = 32'(v);
  endfunction

  // sources are from other logic domains: two-flop synchronisers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxth_sync1 <= '0;
      rxth_sync2 <= '0;
      rx_sync1 <= '0;
      rx_sync2 <= '0;
      tx_sync1 <= '0;
      tx_sync2 <= '0;
      misc_sync1 <= 4'h0;
      misc_sync2 <= 4'h0;
      misc_prev <= 4'h0;
    end else begin
      rxth_sync1 <= rx_thresh_src;
      rxth_sync2 <= rxth_sync1;
      rx_sync1 <= rx_src;
      rx_sync2 <= rx_sync1;
      tx_sync1 <= tx_src;
      tx_sync2 <= tx_sync1;
      misc_sync1 <= {statistics_src, host_error_src, link_change_src, phy_access_src};
      misc_sync2 <= misc_sync1;
      misc_prev <= misc_sync2;
    end
  end

  // masked per-channel state
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gen_mask
      assign receive_threshold_masked_state[g] = rxth_sync2[g] & receive_threshold_mask_bits[g];
      assign rx_masked[g] = rx_sync2[g] & rx_mask[g];
      assign tx_masked[g] = tx_sync2[g] & tx_mask[g];
    end
  endgenerate

  assign statistics_irq_enable = misc_mask[`MISC_STAT_BIT];
  assign host_error_irq_enable = misc_mask[`MISC_HOST_BIT];
  assign link_change_irq_enable = misc_mask[`MISC_LINK_BIT];
  assign phy_access_irq_enable = misc_mask[`MISC_USER_BIT];
  assign misc_raw = {misc_sync2[3], misc_sync2[2], 1'b0, misc_sync2[1], 1'b0, misc_sync2[0]};
  assign misc_active = misc_raw & misc_mask;
  // printed encoding: 0 means occurred
  assign statistics_irq_flag = ~misc_active[`MISC_STAT_BIT];
  assign host_error_irq_flag = ~misc_active[`MISC_HOST_BIT];
  assign link_change_irq_flag = ~misc_active[`MISC_LINK_BIT];
  assign phy_access_irq_flag = ~misc_active[`MISC_USER_BIT];

  assign transmit_pacing_enable = int_control[`BIT_TX_PACE];
  assign receive_pacing_enable = int_control[`BIT_RX_PACE];

  // prescaler and millisecond window
  always_comb begin
    next_pre_cnt = pre_cnt + 12'h001;
    next_win_cnt = win_cnt;
    tick_ms = 1'b0;
    if (pre_cnt + 12'h001 >= int_control[`PRESCALE_MSB:0]) begin
      next_pre_cnt = 12'h000;
      next_win_cnt = win_cnt + 8'h01;
      if (win_cnt == 8'(`WINDOW_TICKS - 1)) begin
        next_win_cnt = 8'h00;
        tick_ms = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt <= 12'h000;
      win_cnt <= 8'h00;
    end else begin
      pre_cnt <= next_pre_cnt;
      win_cnt <= next_win_cnt;
    end
  end

  assign rx_lnk.tick_ms = tick_ms;
  assign rx_lnk.enable = receive_pacing_enable;
  assign rx_lnk.limit = receive_pulse_rate_limit;
  assign rx_lnk.request = |rx_masked;
  assign tx_lnk.tick_ms = tick_ms;
  assign tx_lnk.enable = transmit_pacing_enable;
  assign tx_lnk.limit = transmit_pulse_rate_limit;
  assign tx_lnk.request = |tx_masked;

  pulse_pacer u_rx_pacer (
    .mclk(mclk),
    .rst_b(rst_b),
    .lnk(rx_lnk.pacer)
  );

  pulse_pacer u_tx_pacer (
    .mclk(mclk),
    .rst_b(rst_b),
    .lnk(tx_lnk.pacer)
  );

  assign receive_threshold_irq_line = |receive_threshold_masked_state;
  assign receive_irq_line = rx_lnk.pulse;
  assign transmit_irq_line = tx_lnk.pulse;
  assign misc_irq_line = |misc_active;

  // apb: zero wait states, error on unmapped address
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      `OFS_INT_CONTROL: rd_mux = int_control;
      `OFS_RXTH_MASK: rd_mux = widen(receive_threshold_mask_bits);
      `OFS_RX_MASK: rd_mux = widen(rx_mask);
      `OFS_TX_MASK: rd_mux = widen(tx_mask);
      `OFS_MISC_MASK: rd_mux = {26'h0, misc_mask};
      `OFS_RXTH_STATE: rd_mux = widen(receive_threshold_masked_state);
      `OFS_RX_STATE: rd_mux = widen(rx_masked);
      `OFS_TX_STATE: rd_mux = widen(tx_masked);
      `OFS_MISC_STATE: rd_mux = {26'h0, statistics_irq_flag, host_error_irq_flag, 1'b0,
                                 link_change_irq_flag, 1'b0, phy_access_irq_flag};
      `OFS_RX_LIMIT: rd_mux = {26'h0, receive_pulse_rate_limit};
      `OFS_TX_LIMIT: rd_mux = {26'h0, transmit_pulse_rate_limit};
      `OFS_EVT_STATUS: rd_mux = {28'h0, evt_status};
      `OFS_EVT_MASK: rd_mux = {28'h0, evt_mask};
      default: begin
        rd_mux = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
  end
  assign pslverr = psel & penable & ~hit;
  assign prdata = rd_mux;

  // sticky events: rising edge of any misc source, set wins over clear
  assign evt_rise = misc_sync2 & ~misc_prev;

  always_comb begin
    next_int_control = int_control;
    next_rxth_mask = receive_threshold_mask_bits;
    next_rx_mask = rx_mask;
    next_tx_mask = tx_mask;
    next_misc_mask = misc_mask;
    next_rx_limit = receive_pulse_rate_limit;
    next_tx_limit = transmit_pulse_rate_limit;
    next_evt_mask = evt_mask;
    next_evt_status = evt_status;
    if (wr_en) begin
      case (paddr)
        `OFS_INT_CONTROL: next_int_control = pwdata & 32'h8030_0FFF;
        `OFS_RXTH_MASK: next_rxth_mask = pwdata[CHANNELS-1:0];
        `OFS_RX_MASK: next_rx_mask = pwdata[CHANNELS-1:0];
        `OFS_TX_MASK: next_tx_mask = pwdata[CHANNELS-1:0];
        // reserved bits 3 and 1 are dropped
        `OFS_MISC_MASK: next_misc_mask = pwdata[5:0] & `MISC_VALID_MASK;
        `OFS_RX_LIMIT: next_rx_limit = pwdata[5:0];
        `OFS_TX_LIMIT: next_tx_limit = pwdata[5:0];
        `OFS_EVT_STATUS: next_evt_status = evt_status & ~pwdata[3:0];
        `OFS_EVT_MASK: next_evt_mask = pwdata[3:0];
        default: next_int_control = int_control;
      endcase
    end
    next_evt_status = next_evt_status | evt_rise;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_control <= `RST_INT_CONTROL;
      receive_threshold_mask_bits <= '0;
      rx_mask <= '0;
      tx_mask <= '0;
      misc_mask <= 6'h00;
      receive_pulse_rate_limit <= `RST_LIMIT;
      transmit_pulse_rate_limit <= `RST_LIMIT;
      evt_status <= 4'h0;
      evt_mask <= 4'h0;
    end else begin
      int_control <= next_int_control;
      receive_threshold_mask_bits <= next_rxth_mask;
      rx_mask <= next_rx_mask;
      tx_mask <= next_tx_mask;
      misc_mask <= next_misc_mask;
      receive_pulse_rate_limit <= next_rx_limit;
      transmit_pulse_rate_limit <= next_tx_limit;
      evt_status <= next_evt_status;
      evt_mask <= next_evt_mask;
    end
  end

  assign irq = |(evt_status & evt_mask);

  AST_RXTH_LINE: assert property (@(posedge mclk) disable iff (!rst_b)
    receive_threshold_irq_line == |(rxth_sync2 & receive_threshold_mask_bits))
    else $error("threshold line disagrees with masked sources");
  AST_RX_STATE: assert property (@(posedge mclk) disable iff (!rst_b)
    (psel && !pwrite && paddr == `OFS_RX_STATE) |-> prdata[CHANNELS-1:0] == (rx_sync2 & rx_mask))
    else $error("receive state readback wrong");
  AST_TX_LINE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    (tx_mask == '0) |-> !transmit_irq_line)
    else $error("transmit line with all sources masked");
  AST_MISC_RSVD: assert property (@(posedge mclk) disable iff (!rst_b)
    misc_mask[3] == 1'b0 && misc_mask[1] == 1'b0)
    else $error("reserved misc mask bit set");
  AST_MISC_FLAG: assert property (@(posedge mclk) disable iff (!rst_b)
    (misc_sync2[3] && statistics_irq_enable) |-> !statistics_irq_flag)
    else $error("statistics flag encoding wrong");
  AST_LINK_FLAG: assert property (@(posedge mclk) disable iff (!rst_b)
    !link_change_irq_enable |-> link_change_irq_flag)
    else $error("link flag set while disabled");
  AST_WINDOW: assert property (@(posedge mclk) disable iff (!rst_b)
    tick_ms |-> win_cnt == 8'hF9 ##1 win_cnt == 8'h00)
    else $error("window tick out of place");
  AST_STICKY: assert property (@(posedge mclk) disable iff (!rst_b)
    evt_rise[0] |=> evt_status[0])
    else $error("event lost");
  AST_RX_LINE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    (rx_mask == '0) |-> !receive_irq_line)
    else $error("receive line with all sources masked");
  AST_RXTH_STATE: assert property (@(posedge mclk) disable iff (!rst_b)
    (psel && !pwrite && paddr == `OFS_RXTH_STATE) |->
      prdata[CHANNELS-1:0] == (rxth_sync2 & receive_threshold_mask_bits))
    else $error("threshold state readback wrong");
  AST_TX_STATE: assert property (@(posedge mclk) disable iff (!rst_b)
    (psel && !pwrite && paddr == `OFS_TX_STATE) |->
      prdata[CHANNELS-1:0] == (tx_sync2 & tx_mask))
    else $error("transmit state readback wrong");
  AST_STATE_RSVD: assert property (@(posedge mclk) disable iff (!rst_b)
    (psel && paddr == `OFS_RX_STATE) |-> prdata[31:CHANNELS] == '0)
    else $error("reserved receive state bits not zero");
  AST_HOST_FLAG: assert property (@(posedge mclk) disable iff (!rst_b)
    (misc_sync2[2] && host_error_irq_enable) |-> !host_error_irq_flag)
    else $error("host error flag encoding wrong");
  AST_USER_FLAG: assert property (@(posedge mclk) disable iff (!rst_b)
    !phy_access_irq_enable |-> phy_access_irq_flag)
    else $error("phy access flag set while disabled");
  AST_PRESCALE: assert property (@(posedge mclk) disable iff (!rst_b)
    (int_control[`PRESCALE_MSB:0] != 12'h000 && $stable(int_control[`PRESCALE_MSB:0]))
      |-> pre_cnt < int_control[`PRESCALE_MSB:0])
    else $error("prescaler ran past its period");
  AST_RX_UNPACED: assert property (@(posedge mclk) disable iff (!rst_b)
    !receive_pacing_enable |-> receive_irq_line == |rx_masked)
    else $error("unpaced receive line differs from masked sources");
  AST_TX_UNPACED: assert property (@(posedge mclk) disable iff (!rst_b)
    !transmit_pacing_enable |-> transmit_irq_line == |tx_masked)
    else $error("unpaced transmit line differs from masked sources");
  AST_RX_ZERO_LIMIT: assert property (@(posedge mclk) disable iff (!rst_b)
    (receive_pacing_enable && receive_pulse_rate_limit == 6'h00) |-> !receive_irq_line)
    else $error("receive line with zero allowance");
  AST_TX_ZERO_LIMIT: assert property (@(posedge mclk) disable iff (!rst_b)
    (transmit_pacing_enable && transmit_pulse_rate_limit == 6'h00) |-> !transmit_irq_line)
    else $error("transmit line with zero allowance");
  AST_MISC_LINE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
    (misc_mask == 6'h00) |-> !misc_irq_line)
    else $error("misc line with all sources masked");
endmodule

// >>> verif/irq_source_model.sv
`timescale 1ns/1ps
module irq_source_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // requested source levels from the bench
  input wire logic [27:0] want,
  // raw source levels toward the combiner
  output logic [7:0] rxth,
  output logic [7:0] rx,
  output logic [7:0] tx,
  output logic [3:0] misc
);
  // sources are registered so that they change just after an edge, like real logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {rxth, rx, tx, misc} <= 28'h0000000;
    end else begin
      {rxth, rx, tx, misc} <= want;
    end
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "irq_combiner_defs.svh"
module testbench;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] rxth_s, rx_s, tx_s, m0, m1, m2;
  logic [3:0] misc_s;
  logic [27:0] want;
  logic [5:0] mm;
  logic rxth_l, rx_l, tx_l, misc_l, irq, rx_d, tx_d;
  int errors, n_checks, cyc, rx_edges, tx_edges, seed;
  logic [32:0] exp_q[$];

  irq_combiner #(.CHANNELS(8)) uut (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_thresh_src(rxth_s), .rx_src(rx_s),
    .tx_src(tx_s), .statistics_src(misc_s[3]), .host_error_src(misc_s[2]),
    .link_change_src(misc_s[1]), .phy_access_src(misc_s[0]),
    .receive_threshold_irq_line(rxth_l), .receive_irq_line(rx_l),
    .transmit_irq_line(tx_l), .misc_irq_line(misc_l), .irq(irq));
  irq_source_model far (.mclk(mclk), .rst_b(rst_b), .want(want), .rxth(rxth_s),
    .rx(rx_s), .tx(tx_s), .misc(misc_s));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    if (errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one apb transfer; waits on pready rather than assuming zero wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  function automatic logic [5:0] on6(input logic [3:0] s);
    return {s[3], s[2], 1'b0, s[1], 1'b0, s[0]};
  endfunction

  // n pulses of 4 clocks, one every 10; 60 of them span two or three window ticks
  task automatic burst(input int n);
    rx_edges = 0;
    tx_edges = 0;
    repeat (n) begin
      @(posedge mclk) want <= 28'h00FFFF0;
      repeat (4) @(posedge mclk);
      want <= 28'h0000000;
      repeat (5) @(posedge mclk);
    end
    settle(8);
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) check(64'h0, 64'h1);
      else check({pslverr, prdata}, exp_q.pop_front());
    end
    rx_d <= rx_l;
    tx_d <= tx_l;
    if (rx_l === 1'b1 && rx_d === 1'b0) rx_edges++;
    if (tx_l === 1'b1 && tx_d === 1'b0) tx_edges++;
    if (cyc == 20000) begin
      errors++;
      print_verdict;
    end
  end

  initial begin
    seed = 35922;
    {psel, penable, pwrite, rst_b} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    want = 28'h0000000;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(`OFS_INT_CONTROL, `RST_INT_CONTROL, 1'b0);
    rd(`OFS_MISC_MASK, 32'h00000000, 1'b0);
    rd(`OFS_RX_LIMIT, 32'h0000003F, 1'b0);
    rd(`OFS_TX_LIMIT, 32'h0000003F, 1'b0);
    rd(12'h008, 32'h00000000, 1'b1);
    repeat (4) begin
      r = $random(seed);
      {m0, m1, m2, mm} = r[29:0];
      mm = mm & `MISC_VALID_MASK; // unused bits 3 and 1 written as zero
      wr(`OFS_RXTH_MASK, {24'h000000, m0});
      wr(`OFS_RX_MASK, {24'h000000, m1});
      wr(`OFS_TX_MASK, {24'h000000, m2});
      wr(`OFS_MISC_MASK, {26'h0000000, mm});
      rd(`OFS_MISC_MASK, {26'h0000000, mm}, 1'b0);
      r = $random(seed);
      @(posedge mclk) want <= r[27:0];
      settle(6);
      rd(`OFS_RXTH_STATE, {24'h000000, want[27:20] & m0}, 1'b0);
      rd(`OFS_RX_STATE, {24'h000000, want[19:12] & m1}, 1'b0);
      rd(`OFS_TX_STATE, {24'h000000, want[11:4] & m2}, 1'b0);
      rd(`OFS_MISC_STATE, {26'h0, `MISC_VALID_MASK & ~(on6(want[3:0]) & mm)}, 1'b0);
      settle(1);
      check(rxth_l, |(want[27:20] & m0));
      check(rx_l, |(want[19:12] & m1));
      check(tx_l, |(want[11:4] & m2));
      check(misc_l, |(on6(want[3:0]) & mm));
    end
    // event status: sticky, masked, cleared by writing one
    @(posedge mclk) want <= 28'h0000000;
    settle(6);
    wr(`OFS_EVT_MASK, 32'h00000000);
    wr(`OFS_EVT_STATUS, 32'h0000000F);
    rd(`OFS_EVT_STATUS, 32'h00000000, 1'b0);
    @(posedge mclk) want <= 28'h0000008;
    settle(6);
    rd(`OFS_EVT_STATUS, 32'h00000008, 1'b0);
    check(irq, 1'b0);
    wr(`OFS_EVT_MASK, 32'h00000008);
    settle(1);
    check(irq, 1'b1);
    wr(`OFS_EVT_STATUS, 32'h00000008);
    settle(1);
    check(irq, 1'b0);
    // pacing with a one-clock prescale so a window is 250 clocks
    wr(`OFS_RX_MASK, 32'h000000FF);
    wr(`OFS_TX_MASK, 32'h000000FF);
    wr(`OFS_RX_LIMIT, 32'h00000003);
    wr(`OFS_INT_CONTROL, 32'h00100001);
    burst(60);
    // a full window and a long partial one give 3 each; four windows at most
    check(rx_edges >= 6 && rx_edges <= 12, 1'b1);
    check(tx_edges, 60);
    wr(`OFS_TX_LIMIT, 32'h00000000);
    wr(`OFS_INT_CONTROL, 32'h00200001);
    burst(60);
    check(rx_edges, 60);
    check(tx_edges, 0);
    settle(2);
    print_verdict;
  end
endmodule
